// [shared/sdis_map.svh]
`ifndef SDIS_MAP_SVH
`define SDIS_MAP_SVH
// register byte offsets
`define SDIS_OFS_CTRL      8'h00
`define SDIS_OFS_DYNCTL    8'h04
`define SDIS_OFS_REFRESH   8'h08
`define SDIS_OFS_CONFIG    8'h0c
`define SDIS_OFS_RASCAS0   8'h10
`define SDIS_OFS_RASCAS1   8'h14
`define SDIS_OFS_TIMING    8'h18
`define SDIS_OFS_CLKDIV    8'h1c
`define SDIS_OFS_STATUS    8'h20
// dynamic_memory_control fields
`define SDIS_DC_CKE_BIT    0
`define SDIS_DC_CLK_BIT    1
`define SDIS_DC_INV_BIT    4
`define SDIS_DC_CMD_HI     8
`define SDIS_DC_CMD_LO     7
`define SDIS_CMD_NORMAL    2'h0
`define SDIS_CMD_MODE      2'h1
`define SDIS_CMD_PALL      2'h2
`define SDIS_CMD_NOP       2'h3
// controller control fields
`define SDIS_CT_EN_BIT     0
`define SDIS_CT_BUF_BIT    1
// reset values
`define SDIS_RST_DYNCTL    32'h0000_0183
`define SDIS_RST_RASCAS    32'h0000_0303
`define SDIS_RST_TIMING    32'h0101_ff07
`define SDIS_RST_CONFIG    32'h0000_0065
// timing
`define SDIS_CLK_MHZ       100
`define SDIS_NOP_TIME_US   200
`define SDIS_PALL_TIME_US  10
// address regions, from byte address bits 27:26
`define SDIS_REG_REGS      2'h0
`define SDIS_REG_CS0       2'h1
`define SDIS_REG_CS1       2'h2
`endif

// [shared/sdis_pkg.sv]
package sdis_pkg;
  typedef struct packed {
    logic [1:0] cs_b;
    logic       ras_b;
    logic       cas_b;
    logic       we_b;
  } sdis_cmd_type;

  typedef struct packed {
    logic       row_bank_column_order;
    logic       bus32;
    logic [3:0] col_bits;
    logic [1:0] bank_bits;
  } sdis_cfg_type;

  typedef enum logic [1:0] {BUS_IDLE, BUS_ACK, BUS_MODE} sdis_bus_type;
endpackage : sdis_pkg

// [rtl/sdis_init_seq.sv]
// Chosen here: the Avalon-MM register port and the register offsets.
`timescale 1ns/10ps
`include "sdis_map.svh"

// Contract
// RQ1 - nop command selected by 0x183 drives NOP continuously; 200 us measured
// RQ2 - command field bits 8:7, bit 0 forces cke, bit 1 forces clock
// RQ3 - inverted clock bit 4 is held clear for single rate operation
// RQ4 - precharge-all selected by 0x103, clocks and cke forced, 10 us measured
// RQ5 - fast refresh interval during precharge gives several auto-refreshes
// RQ6 - reloaded normal refresh interval keeps issuing auto-refresh commands
// RQ7 - mode-state write to region base plus shifted word drives word on address
// RQ8 - shift is column bits, plus bank bits for rbc, plus one or two
// RQ9 - host waits about 1 us after mode write before further access
// RQ10 - mode word burst length one for 32-bit bus, two for 16-bit
// RQ11 - mode word cas latency equals the chip select's cas delay field
// RQ12 - second chip select gets its own mode write cycle
// RQ13 - buffer enable only accepted once command field is normal
// RQ14 - latency and timing fields count memory bus clock periods
// RQ15 - self-refresh exit delay resets to its maximum value
// RQ16 - memory clock is system clock divided by field plus one
// RQ17 - ras and cas latency accept only two or three clocks
// RQ18 - nothing happens until controller enable bit is set
// RQ19 - refresh timer issues auto-refresh on each elapsed interval
module sdis_init_seq #(
  parameter int NOP_CYCLES = `SDIS_NOP_TIME_US * `SDIS_CLK_MHZ
) (
  input  wire logic                clk,
  input  wire logic                rst_b,
  input  wire logic [27:0]         avs_address,
  input  wire logic                avs_read,
  input  wire logic                avs_write,
  input  wire logic [31:0]         avs_writedata,
  output logic [31:0]              avs_readdata,
  output logic                     avs_waitrequest,
  output sdis_pkg::sdis_cmd_type   sd_cmd,
  output logic [14:0]              sd_addr,
  output logic                     sd_cke,
  output logic                     sd_clk_run,
  output logic                     sd_clk_tick
);
  localparam int PALL_CYCLES = `SDIS_PALL_TIME_US * `SDIS_CLK_MHZ;

  localparam sdis_pkg::sdis_cmd_type CMD_DESEL = '{2'h3, 1'b1, 1'b1, 1'b1};

  function automatic logic [4:0] mode_shift(input sdis_pkg::sdis_cfg_type c);
    logic [4:0] s;
    s = {1'b0, c.col_bits} + (c.row_bank_column_order ? {3'h0, c.bank_bits} : 5'h00); // RQ8
    mode_shift = s + (c.bus32 ? 5'h02 : 5'h01); // RQ8
  endfunction : mode_shift

  function automatic logic [1:0] lat_ok(input logic [1:0] nw, input logic [1:0] old);
    lat_ok = (nw == 2'h2 || nw == 2'h3) ? nw : old; // RQ17
  endfunction : lat_ok

  logic [31:0]             ctrl, next_ctrl;
  logic [31:0]             dynctl, next_dynctl;
  logic [15:0]             refresh, next_refresh;
  sdis_pkg::sdis_cfg_type  cfg, next_cfg;
  logic [9:0]              rascas0, next_rascas0;
  logic [9:0]              rascas1, next_rascas1;
  logic [31:0]             timing, next_timing;
  logic [7:0]              clkdiv, next_clkdiv;
  sdis_pkg::sdis_bus_type  bus, next_bus;
  logic [31:0]             rdata, next_rdata;
  logic [7:0]              div_cnt, next_div_cnt;
  logic                    tick, next_tick;
  logic [19:0]             ref_cnt, next_ref_cnt;
  logic                    ref_pend, next_ref_pend;
  logic [7:0]              busy, next_busy;
  logic                    pall_done, next_pall_done;
  logic [15:0]             phase, next_phase;
  logic [1:0]              last_cmd, next_last_cmd;
  logic [15:0]             ref_count, next_ref_count;
  logic                    mode_cs, next_mode_cs;
  logic [14:0]             mode_word, next_mode_word;
  sdis_pkg::sdis_cmd_type  cmd, next_cmd;
  logic [14:0]             addr, next_addr;
  logic                    cke, next_cke;
  logic                    clk_run, next_clk_run;
  logic                    wait_q, next_wait_q;

  logic [1:0]              cmd_sel;
  logic                    enabled;
  logic                    req;
  logic [1:0]              region;
  logic [7:0]              ofs;
  logic [27:0]             shifted;
  logic [9:0]              rc_sel;
  logic                    nop_elapsed;
  logic                    pall_elapsed;

  always_comb begin
    cmd_sel      = dynctl[`SDIS_DC_CMD_HI:`SDIS_DC_CMD_LO]; // RQ2
    enabled      = ctrl[`SDIS_CT_EN_BIT];
    req          = avs_read | avs_write;
    region       = avs_address[27:26];
    ofs          = avs_address[7:0];
    // mode word comes from the offset inside the chip select region only
    shifted      = {2'b00, avs_address[25:0]} >> mode_shift(cfg); // RQ7
    nop_elapsed  = (last_cmd == `SDIS_CMD_NOP) && (32'(phase) >= NOP_CYCLES); // RQ1
    pall_elapsed = (last_cmd == `SDIS_CMD_PALL) && (32'(phase) >= PALL_CYCLES); // RQ4
    rc_sel       = mode_cs ? rascas1 : rascas0;

    next_ctrl      = ctrl;
    next_dynctl    = dynctl;
    next_refresh   = refresh;
    next_cfg       = cfg;
    next_rascas0   = rascas0;
    next_rascas1   = rascas1;
    next_timing    = timing;
    next_clkdiv    = clkdiv;
    next_bus       = bus;
    next_rdata     = rdata;
    next_mode_cs   = mode_cs;
    next_mode_word = mode_word;
    next_ref_count = ref_count;

    // memory clock enable, divide by field plus one
    next_tick    = 1'b0;
    next_div_cnt = div_cnt + 8'h01;
    if (div_cnt >= clkdiv) begin
      next_div_cnt = 8'h00;
      next_tick    = enabled; // RQ16 RQ18
    end

    next_last_cmd = cmd_sel;
    next_phase    = (cmd_sel != last_cmd || !enabled) ? 16'h0000 :
                    ((phase == 16'hffff) ? phase : phase + 16'h0001);

    // refresh interval in units of sixteen memory clocks
    next_ref_cnt  = ref_cnt;
    next_ref_pend = ref_pend;
    if (tick && refresh != 16'h0000) begin
      if (ref_cnt == 20'h00000) begin
        next_ref_cnt  = {refresh, 4'h0}; // RQ5 RQ6
        next_ref_pend = 1'b1; // RQ19
      end else begin
        next_ref_cnt = ref_cnt - 20'h00001;
      end
    end

    next_busy      = busy;
    next_pall_done = pall_done && (cmd_sel == `SDIS_CMD_PALL);
    next_cmd       = cmd;
    next_addr      = addr;
    next_cke       = enabled & (dynctl[`SDIS_DC_CKE_BIT] | (cmd_sel == `SDIS_CMD_NORMAL)); // RQ2
    next_clk_run   = enabled & (dynctl[`SDIS_DC_CLK_BIT] | (cmd_sel == `SDIS_CMD_NORMAL)); // RQ2

    if (tick) begin
      next_cmd = CMD_DESEL;
      if (busy != 8'h00) begin
        next_busy = busy - 8'h01; // RQ14
      end
      case (cmd_sel)
        `SDIS_CMD_NOP: begin
          next_cmd = '{2'h0, 1'b1, 1'b1, 1'b1}; // RQ1
        end
        `SDIS_CMD_PALL: begin
          if (!pall_done) begin
            next_cmd       = '{2'h0, 1'b0, 1'b1, 1'b0}; // RQ4
            next_addr      = 15'h0400;
            next_pall_done = 1'b1;
            next_busy      = timing[7:0];
          end
        end
        `SDIS_CMD_MODE: begin
          if (bus == sdis_pkg::BUS_MODE && busy == 8'h00 && !ref_pend) begin
            next_cmd       = mode_cs ? sdis_pkg::sdis_cmd_type'{2'h1, 1'b0, 1'b0, 1'b0} :
                                       sdis_pkg::sdis_cmd_type'{2'h2, 1'b0, 1'b0, 1'b0}; // RQ12
            next_addr      = mode_word;
            next_addr[2:0] = cfg.bus32 ? 3'h0 : 3'h1; // RQ10
            next_addr[6:4] = {1'b0, rc_sel[9:8]}; // RQ11
            next_busy      = timing[31:24]; // RQ14
            next_bus       = sdis_pkg::BUS_ACK;
          end
        end
        default: begin
        end
      endcase
      if (cmd_sel != `SDIS_CMD_NOP && busy == 8'h00 && ref_pend &&
          !(cmd_sel == `SDIS_CMD_PALL && !pall_done)) begin
        next_cmd       = '{2'h0, 1'b0, 1'b0, 1'b1}; // RQ5 RQ6 RQ19
        // an interval ending on this very tick stays pending
        next_ref_pend  = (refresh != 16'h0000) && (ref_cnt == 20'h00000);
        next_busy      = timing[7:0]; // RQ14
        next_ref_count = ref_count + 16'h0001;
      end
    end

    case (bus)
      sdis_pkg::BUS_IDLE: begin
        if (req) begin
          next_bus   = sdis_pkg::BUS_ACK;
          next_rdata = 32'h0000_0000;
          if (region == `SDIS_REG_REGS) begin
            if (avs_write) begin
              if (ofs == `SDIS_OFS_CTRL) begin
                next_ctrl[`SDIS_CT_EN_BIT] = avs_writedata[`SDIS_CT_EN_BIT]; // RQ18
                if (cmd_sel == `SDIS_CMD_NORMAL) begin
                  next_ctrl[`SDIS_CT_BUF_BIT] = avs_writedata[`SDIS_CT_BUF_BIT]; // RQ13
                end
              end else if (ofs == `SDIS_OFS_DYNCTL) begin
                next_dynctl = avs_writedata & 32'h0000_0183;
                next_dynctl[`SDIS_DC_INV_BIT] = 1'b0; // RQ3
                if (avs_writedata[8:7] != `SDIS_CMD_NORMAL) begin
                  next_ctrl[`SDIS_CT_BUF_BIT] = 1'b0; // RQ13
                end
              end else if (ofs == `SDIS_OFS_REFRESH) begin
                next_refresh = avs_writedata[15:0];
                next_ref_cnt = {avs_writedata[15:0], 4'h0}; // RQ6
              end else if (ofs == `SDIS_OFS_CONFIG) begin
                next_cfg = avs_writedata[7:0];
              end else if (ofs == `SDIS_OFS_RASCAS0) begin
                next_rascas0 = {lat_ok(avs_writedata[9:8], rascas0[9:8]), 6'h00,
                                lat_ok(avs_writedata[1:0], rascas0[1:0])}; // RQ17
              end else if (ofs == `SDIS_OFS_RASCAS1) begin
                next_rascas1 = {lat_ok(avs_writedata[9:8], rascas1[9:8]), 6'h00,
                                lat_ok(avs_writedata[1:0], rascas1[1:0])}; // RQ17
              end else if (ofs == `SDIS_OFS_TIMING) begin
                next_timing = avs_writedata; // RQ14
              end else if (ofs == `SDIS_OFS_CLKDIV) begin
                next_clkdiv = avs_writedata[7:0]; // RQ16
              end
            end else begin
              if (ofs == `SDIS_OFS_CTRL) begin
                next_rdata = ctrl;
              end else if (ofs == `SDIS_OFS_DYNCTL) begin
                next_rdata = dynctl;
              end else if (ofs == `SDIS_OFS_REFRESH) begin
                next_rdata = {16'h0000, refresh};
              end else if (ofs == `SDIS_OFS_CONFIG) begin
                next_rdata = {24'h000000, cfg};
              end else if (ofs == `SDIS_OFS_RASCAS0) begin
                next_rdata = {22'h0, rascas0};
              end else if (ofs == `SDIS_OFS_RASCAS1) begin
                next_rdata = {22'h0, rascas1};
              end else if (ofs == `SDIS_OFS_TIMING) begin
                next_rdata = timing;
              end else if (ofs == `SDIS_OFS_CLKDIV) begin
                next_rdata = {24'h000000, clkdiv};
              end else if (ofs == `SDIS_OFS_STATUS) begin
                next_rdata = {ref_count, 9'h000, pall_done, ref_pend, busy == 8'h00,
                              pall_elapsed, nop_elapsed, cmd_sel};
              end
            end
          end else if (avs_write && enabled && cmd_sel == `SDIS_CMD_MODE &&
                       region != 2'h3) begin
            next_bus       = sdis_pkg::BUS_MODE; // RQ7
            next_mode_cs   = (region == `SDIS_REG_CS1); // RQ12
            next_mode_word = shifted[14:0]; // RQ7
          end
        end
      end
      sdis_pkg::BUS_ACK: begin
        next_bus = sdis_pkg::BUS_IDLE;
      end
      sdis_pkg::BUS_MODE: begin
        if (cmd_sel != `SDIS_CMD_MODE || !enabled) begin
          next_bus = sdis_pkg::BUS_ACK;
        end
      end
      default: begin
        next_bus = sdis_pkg::BUS_IDLE;
      end
    endcase
    next_wait_q = (next_bus != sdis_pkg::BUS_ACK);
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl      <= 32'h0000_0000;
      dynctl    <= `SDIS_RST_DYNCTL;
      refresh   <= 16'h0000;
      cfg       <= 8'(`SDIS_RST_CONFIG);
      rascas0   <= 10'(`SDIS_RST_RASCAS);
      rascas1   <= 10'(`SDIS_RST_RASCAS);
      timing    <= `SDIS_RST_TIMING; // RQ15
      clkdiv    <= 8'h00;
      bus       <= sdis_pkg::BUS_IDLE;
      rdata     <= 32'h0000_0000;
      div_cnt   <= 8'h00;
      tick      <= 1'b0;
      ref_cnt   <= 20'h00000;
      ref_pend  <= 1'b0;
      busy      <= 8'h00;
      pall_done <= 1'b0;
      phase     <= 16'h0000;
      last_cmd  <= `SDIS_CMD_NOP;
      ref_count <= 16'h0000;
      mode_cs   <= 1'b0;
      mode_word <= 15'h0000;
      cmd       <= CMD_DESEL;
      addr      <= 15'h0000;
      cke       <= 1'b0;
      clk_run   <= 1'b0;
      wait_q    <= 1'b1;
    end else begin
      ctrl      <= next_ctrl;
      dynctl    <= next_dynctl;
      refresh   <= next_refresh;
      cfg       <= next_cfg;
      rascas0   <= next_rascas0;
      rascas1   <= next_rascas1;
      timing    <= next_timing;
      clkdiv    <= next_clkdiv;
      bus       <= next_bus;
      rdata     <= next_rdata;
      div_cnt   <= next_div_cnt;
      tick      <= next_tick;
      ref_cnt   <= next_ref_cnt;
      ref_pend  <= next_ref_pend;
      busy      <= next_busy;
      pall_done <= next_pall_done;
      phase     <= next_phase;
      last_cmd  <= next_last_cmd;
      ref_count <= next_ref_count;
      mode_cs   <= next_mode_cs;
      mode_word <= next_mode_word;
      cmd       <= next_cmd;
      addr      <= next_addr;
      cke       <= next_cke;
      clk_run   <= next_clk_run;
      wait_q    <= next_wait_q;
    end
  end

  assign avs_readdata    = rdata;
  assign avs_waitrequest = wait_q;
  assign sd_cmd          = cmd;
  assign sd_addr         = addr;
  assign sd_cke          = cke;
  assign sd_clk_run      = clk_run;
  assign sd_clk_tick     = tick;
endmodule : sdis_init_seq

// [testbench/sdis_init_seq_asserts.sv]
`timescale 1ns/10ps
module sdis_init_seq_asserts (
  input wire logic                   clk,
  input wire logic                   rst_b,
  input wire logic [27:0]            avs_address,
  input wire logic                   avs_read,
  input wire logic                   avs_write,
  input wire logic [31:0]            avs_writedata,
  input wire logic [31:0]            avs_readdata,
  input wire logic                   avs_waitrequest,
  input wire sdis_pkg::sdis_cmd_type sd_cmd,
  input wire logic [14:0]            sd_addr,
  input wire logic                   sd_cke,
  input wire logic                   sd_clk_run,
  input wire logic                   sd_clk_tick
);
  logic is_mode;
  assign is_mode = sd_cmd[2:0] == 3'h0 && sd_cmd.cs_b != 2'h3;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_cmd_on_tick: assert property (!$past(sd_clk_tick) |-> $stable(sd_cmd))
    else $error("command changed off the memory clock tick");
  a_pall_addr: assert property (sd_cmd == 5'h02 |-> sd_addr[10])
    else $error("precharge-all without all-banks address bit");
  a_mode_fields: assert property (is_mode |-> sd_addr[6:4] inside {3'h2, 3'h3})
    else $error("mode word latency out of range");
  a_mode_burst: assert property (is_mode |-> sd_addr[2:1] == 2'h0)
    else $error("mode word burst code wrong");
  a_mode_ack: assert property ($rose(is_mode) |-> !avs_waitrequest ##1 avs_waitrequest)
    else $error("mode write not acked with the mode command");
  a_read_quick: assert property ($rose(avs_read) |=> !avs_waitrequest)
    else $error("register read not answered next cycle");
  a_cmd_clocked: assert property (sd_cmd != 5'h1f |-> sd_cke && sd_clk_run)
    else $error("command issued with clock or clock enable off");
  a_mode_one_cs: assert property (is_mode |-> $onehot(~sd_cmd.cs_b))
    else $error("mode command not on exactly one chip select");
  c_mode: cover property (is_mode);
  c_pall: cover property (sd_cmd == 5'h02);
  c_ref: cover property (sd_cmd == 5'h01);
endmodule : sdis_init_seq_asserts

bind sdis_init_seq sdis_init_seq_asserts chk_u (.clk(clk), .rst_b(rst_b),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .sd_cmd(sd_cmd), .sd_addr(sd_addr),
  .sd_cke(sd_cke), .sd_clk_run(sd_clk_run), .sd_clk_tick(sd_clk_tick));

// [testbench/sdis_sdram_model.sv]
`timescale 1ns/10ps
module sdis_sdram_model (
  input wire logic                   clk,
  input wire logic                   rst_b,
  input wire sdis_pkg::sdis_cmd_type sd_cmd,
  input wire logic [14:0]            sd_addr,
  input wire logic                   sd_cke,
  input wire logic                   sd_clk_tick,
  output logic [31:0]                nop_cnt,
  output logic [31:0]                ref_cnt,
  output logic [31:0]                err_cnt,
  output logic [14:0]                mode0,
  output logic [14:0]                mode1
);
  logic pall_seen;
  // the memory latches a command on its clock edge, i.e. at the tick
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      nop_cnt <= 0;
      ref_cnt <= 0;
      err_cnt <= 0;
      mode0 <= 0;
      mode1 <= 0;
      pall_seen <= 0;
    end else if (sd_clk_tick && sd_cke) begin
      case (sd_cmd)
        5'h07: nop_cnt <= nop_cnt + 1;
        5'h02: pall_seen <= 1'b1;
        5'h01: ref_cnt <= ref_cnt + 1;
        5'h10: mode0 <= sd_addr;
        5'h08: mode1 <= sd_addr;
        default: ;
      endcase
      // mode or refresh before any precharge-all is illegal for the memory
      if (!pall_seen && (sd_cmd == 5'h10 || sd_cmd == 5'h08 || sd_cmd == 5'h01)) begin
        err_cnt <= err_cnt + 1;
      end
    end
  end
endmodule : sdis_sdram_model

// [testbench/sdis_init_seq_tb.sv]
`timescale 1ns/10ps
module sdis_init_seq_tb;
  logic clk, rst_b, avs_read, avs_write, avs_waitrequest, sd_cke, sd_clk_run, sd_clk_tick;
  logic [27:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q, nop_cnt, ref_cnt, err_cnt;
  logic [14:0] sd_addr, mode0, mode1;
  sdis_pkg::sdis_cmd_type sd_cmd;
  integer seed, fail_count, checked, n, t, sh, i;
  logic [3:0] col;
  logic row_bank_column_order, b32;
  logic [1:0] cas0, cas1, div;
  logic [10:0] w0, w1;
  localparam logic [7:0] OFS [7] = '{8'h00, 8'h04, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c};
  localparam logic [31:0] RV [7] = '{32'h0, 32'h183, 32'h65, 32'h303, 32'h303,
                                     32'h0101ff07, 32'h0};

  sdis_init_seq #(.NOP_CYCLES(50)) dut_u (.clk(clk), .rst_b(rst_b),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .sd_cmd(sd_cmd), .sd_addr(sd_addr),
    .sd_cke(sd_cke), .sd_clk_run(sd_clk_run), .sd_clk_tick(sd_clk_tick));
  sdis_sdram_model mem_u (.clk(clk), .rst_b(rst_b), .sd_cmd(sd_cmd), .sd_addr(sd_addr),
    .sd_cke(sd_cke), .sd_clk_tick(sd_clk_tick), .nop_cnt(nop_cnt), .ref_cnt(ref_cnt),
    .err_cnt(err_cnt), .mode0(mode0), .mode1(mode1));

  task wrap_up();
    $display("checked=%0d fail_count=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      fail_count++;
    end
  endtask : chk

  // request held until waitrequest is sampled low
  task bus(input logic wr, input logic [27:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 5000);
    q = avs_readdata;
    if (n >= 5000) begin
      fail_count++;
      wrap_up();
    end
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask : bus

  function automatic logic [31:0] exp_mode(input logic [10:0] w, input logic [1:0] c,
                                           input logic b);
    logic [31:0] r;
    r = {21'h0, w};
    r[6:4] = {1'b0, c};
    r[2:0] = b ? 3'h0 : 3'h1;
    return r;
  endfunction : exp_mode

  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end

  initial begin
    seed = 32'h373f4544;
    fail_count = 0;
    checked = 0;
    rst_b = 0;
    avs_read = 0;
    avs_write = 0;
    avs_address = 0;
    avs_writedata = 0;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    for (i = 0; i < 7; i++) begin
      bus(0, {20'h0, OFS[i]}, 0);
      chk(q, RV[i]);
    end
    bus(0, 28'hc000000, 0);
    chk(q, 0);
    col = 4'h8 + 4'($random(seed) & 3);
    row_bank_column_order = 1'($random(seed));
    b32 = 1'($random(seed));
    cas0 = 2'h2 + 2'($random(seed) & 1);
    cas1 = cas0 ^ 2'h1;
    div = 2'h1 + 2'($random(seed) & 1);
    w0 = 11'($random(seed));
    w1 = 11'($random(seed));
    bus(1, 28'h0c, {24'h0, row_bank_column_order, b32, col, 2'h2});
    bus(1, 28'h10, 32'h102);
    bus(0, 28'h10, 0);
    chk(q, 32'h302);
    bus(1, 28'h10, {22'h0, cas0, 8'h2});
    bus(1, 28'h14, {22'h0, cas1, 8'h2});
    bus(1, 28'h1c, {30'h0, div});
    bus(1, 28'h04, 32'h193);
    bus(0, 28'h04, 0);
    chk(q, 32'h183);
    repeat (20) @(posedge clk);
    chk({30'h0, sd_clk_run, sd_cke} | nop_cnt, 0);
    bus(1, 28'h00, 32'h3);
    bus(0, 28'h00, 0);
    chk(q, 32'h1);
    n = 0;
    while (sd_clk_tick !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    if (n >= 20) begin
      fail_count++;
      wrap_up();
    end
    t = 0;
    do begin
      @(posedge clk);
      t++;
    end while (sd_clk_tick !== 1'b1 && t < 20);
    chk(32'(t), {30'h0, div} + 32'h1);
    chk({30'h0, sd_clk_run, sd_cke}, 32'h3);
    repeat (60) @(posedge clk);
    bus(0, 28'h20, 0);
    chk({31'h0, q[2] && nop_cnt > 0}, 1);
    bus(1, 28'h04, 32'h103);
    bus(1, 28'h08, 32'h1);
    repeat (1000) @(posedge clk);
    bus(0, 28'h20, 0);
    chk({30'h0, q[3], q[6]}, 3);
    chk({31'h0, ref_cnt >= 2}, 1);
    bus(1, 28'h08, 32'h4);
    t = ref_cnt;
    bus(1, 28'h04, 32'h083);
    sh = col + (row_bank_column_order ? 2 : 0) + (b32 ? 2 : 1);
    bus(1, 28'h4000000 | (28'(w0) << sh), $random(seed));
    repeat (100) @(posedge clk);
    chk({17'h0, mode0}, exp_mode(w0, cas0, b32));
    bus(1, 28'h8000000 | (28'(w1) << sh), $random(seed));
    repeat (100) @(posedge clk);
    chk({17'h0, mode1}, exp_mode(w1, cas1, b32));
    bus(1, 28'h04, 32'h0);
    bus(1, 28'h00, 32'h3);
    bus(0, 28'h00, 0);
    chk(q, 32'h3);
    repeat (2000) @(posedge clk);
    chk({31'h0, ref_cnt > t + 2}, 1);
    chk(err_cnt, 0);
    wrap_up();
  end
endmodule : sdis_init_seq_tb
